// [src/mst_defines.vh]
// constants of the microstep translator and chopper control block
// assumes a 125 MHz pclk and an apb master with 32-bit data
`ifndef MST_DEFINES_VH
`define MST_DEFINES_VH

// clock rate
`define MST_CLK_MHZ 16'd125

// register byte offsets
`define MST_ADDR_CTRL 12'h000
`define MST_ADDR_STATUS 12'h004
`define MST_ADDR_LEVELS 12'h008

// control register field and reset value
`define MST_CTRL_OFF_LSB 0
`define MST_CTRL_OFF_MSB 7
`define MST_CTRL_OFF_RST 8'h1e

// levels register field positions
`define MST_LVL1_LSB 0
`define MST_LVL1_NEG 14
`define MST_LVL2_LSB 16
`define MST_LVL2_NEG 30

// translator home and reset decay
`define MST_HOME_POS 5'h04
`define MST_DECAY_RST 2'h3

// blank time in ns and its cycle count at 8 ns per cycle
`define MST_BLANK_NS 16'd1000
`define MST_BLANK_CYC 16'd125

// default off-time in us and its cycle count
`define MST_OFF_DEF_US 16'd30
`define MST_OFF_DEF_CYC (`MST_OFF_DEF_US * `MST_CLK_MHZ)

// fast part of mixed decay: 31.25 percent = 5/16
`define MST_FAST_NUM 3'd5
`define MST_FAST_SHIFT 4

// chopper states
`define MST_ST_DIS 2'd0
`define MST_ST_DRV 2'd1
`define MST_ST_OFF 2'd2

// sine magnitudes per eighth step, hundredths of a percent
`define MST_MAG0 14'h0000
`define MST_MAG1 14'h079f
`define MST_MAG2 14'h0ef3
`define MST_MAG3 14'h15b4
`define MST_MAG4 14'h1b9f
`define MST_MAG5 14'h207b
`define MST_MAG6 14'h2417
`define MST_MAG7 14'h2650
`define MST_MAG8 14'h2710

`endif

// [src/mst_translator.v]
// microstep translator, automatic decay select and two-bridge chopper control
// assumes pins arrive asynchronous to pclk and an apb master on pclk
//
// Function
// R1 - reset loads home levels, mixed decay
// R2 - step rising edge advances one increment
// R3 - resolution inputs pick full/half/quarter/eighth
// R4 - resolution sampled only at step edge
// R5 - direction low clockwise, high counterclockwise
// R6 - lower new level selects mixed decay
// R7 - higher or equal level selects slow
// R8 - reset holds home, outputs off, steps ignored
// R9 - diagonal on, trip turns off switches
// R10 - trip level is step percent of full-scale
// R11 - off-time default or programmed after trip
// R12 - comparator blanked after outputs switch
// R13 - regulator fault disables outputs
// R14 - enable high disables outputs, translator runs
// R15 - overtemp or pump undervoltage disables outputs
// R16 - lockout disables outputs, homes translator
// R17 - sleep disables outputs, wake homes motor
// R18 - controller waits 1 ms after wake
// R19 - mixed decay fast for 31.25 percent
// R20 - synchronous rectification stops at zero current
// R21 - home is 45 degrees, equal currents
// R22 - position in eighths, wraps at 32
`include "mst_defines.vh"

module mst_translator (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // step controller pins
   input wire step,
   input wire dir,
   input wire resolution_select_low,
   input wire resolution_select_high,
   input wire reset_n,
   input wire enable_n,
   input wire sleep_n,
   // supervisor pins
   input wire internal_gate_regulator_fault,
   input wire overtemp_fault,
   input wire charge_pump_supply_low,
   input wire supply_lockout,
   input wire offtime_timing_pin,
   // current sense comparators and zero detect
   input wire phase_one_sense_trip,
   input wire phase_two_sense_trip,
   input wire phase_one_zero_current,
   input wire phase_two_zero_current,
   // current level outputs
   output reg [13:0] phase_one_level,
   output reg phase_one_negative,
   output reg [13:0] phase_two_level,
   output reg phase_two_negative,
   output reg [1:0] decay_mixed,
   // bridge gates {source a, sink a, source b, sink b}
   output wire [3:0] phase_one_gates,
   output wire [3:0] phase_two_gates
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [15:0] pin_raw;
reg [15:0] s1_ff;
reg [15:0] s2_ff;
reg [15:0] s3_ff;
reg [15:0] pin_ff;
wire [15:0] pin_diff;

assign pin_raw = {phase_two_zero_current, phase_one_zero_current,
                  phase_two_sense_trip, phase_one_sense_trip,
                  offtime_timing_pin, supply_lockout, charge_pump_supply_low,
                  overtemp_fault, internal_gate_regulator_fault,
                  sleep_n, enable_n, reset_n, resolution_select_high,
                  resolution_select_low, dir, step};
assign pin_diff = s2_ff ^ s3_ff;

// edges are found on the filtered level, so a one-cycle glitch never counts
// three stages, value taken once stages two and three agree
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      s1_ff <= 16'h0000;
      s2_ff <= 16'h0000;
      s3_ff <= 16'h0000;
      pin_ff <= 16'h0000;
   end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & ~pin_diff) | (pin_ff & pin_diff);
   end
end

wire step_lvl = pin_ff[0];
wire dir_lvl = pin_ff[1];
wire [1:0] res_sel = pin_ff[3:2];
wire rst_pin_n = pin_ff[4];
wire en_pin_n = pin_ff[5];
wire sleep_pin_n = pin_ff[6];
wire reg_fault = pin_ff[7];
wire ot_fault = pin_ff[8];
wire cp_low = pin_ff[9];
wire lockout = pin_ff[10];
wire timing_high = pin_ff[11];
wire [1:0] trip_lvl = pin_ff[13:12];
wire [1:0] zero_lvl = pin_ff[15:14];

////////////////////////////////////////////////////////////////////////
// apb registers

reg [7:0] off_us_ff;
wire apb_setup = psel & ~penable;
wire apb_wr = psel & penable & pwrite;
wire [31:0] status_word;
wire [31:0] levels_word;

// no wait states: every access ends in its first access cycle
assign pready = 1'b1;

// control write, registered read data and error at setup
// status and levels ignore writes and raise no error
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      off_us_ff <= `MST_CTRL_OFF_RST;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
   end else begin
      if (apb_wr && paddr == `MST_ADDR_CTRL) begin
         off_us_ff <= pwdata[`MST_CTRL_OFF_MSB:`MST_CTRL_OFF_LSB];
      end
      if (apb_setup) begin
         pslverr <= 1'b0;
         case (paddr)
            `MST_ADDR_CTRL: prdata <= {24'h000000, off_us_ff};
            `MST_ADDR_STATUS: prdata <= status_word;
            `MST_ADDR_LEVELS: prdata <= levels_word;
            default: begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////
// translator

// sine magnitude of a position in eighth steps
// the second half of each quarter-cycle pair mirrors the first
function [13:0] mst_mag;
   input [4:0] idx;
   reg [3:0] k;
   begin
      k = idx[3] ? (4'd8 - {1'b0, idx[2:0]}) : {1'b0, idx[2:0]};
      case (k)
         4'd0: mst_mag = `MST_MAG0;
         4'd1: mst_mag = `MST_MAG1;
         4'd2: mst_mag = `MST_MAG2;
         4'd3: mst_mag = `MST_MAG3;
         4'd4: mst_mag = `MST_MAG4;
         4'd5: mst_mag = `MST_MAG5;
         4'd6: mst_mag = `MST_MAG6;
         4'd7: mst_mag = `MST_MAG7;
         default: mst_mag = `MST_MAG8;
      endcase
   end
endfunction

reg [4:0] pos_ff;
reg step_prev_ff;
reg [4:0] step_size;
reg [4:0] nxt_pos;
wire [4:0] nxt_cos_idx;
wire [13:0] nxt_lvl1;
wire [13:0] nxt_lvl2;
wire step_rise;
wire home_hold;

// reset pin, lockout and sleep keep the translator at home
// homing wins over a step, so a step in reset, sleep or lockout is lost
assign home_hold = ~rst_pin_n | lockout | ~sleep_pin_n; // [R8] [R16] [R17]
assign step_rise = step_lvl & ~step_prev_ff; // [R2]

// increment size from resolution select
// full step moves eight eighth-step positions, eighth step moves one
always @* begin
   case (res_sel) // [R3]
      2'b00: step_size = 5'h08;
      2'b01: step_size = 5'h04;
      2'b10: step_size = 5'h02;
      default: step_size = 5'h01;
   endcase
   nxt_pos = dir_lvl ? (pos_ff + step_size) : (pos_ff - step_size); // [R5] [R22]
end

// phase one follows cosine, phase two sine of the step angle
assign nxt_cos_idx = nxt_pos + 5'h08;
assign nxt_lvl1 = mst_mag(nxt_cos_idx);
assign nxt_lvl2 = mst_mag(nxt_pos);

// position, levels, polarity and automatic decay select
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      step_prev_ff <= 1'b0;
      pos_ff <= `MST_HOME_POS; // [R1] [R21]
      phase_one_level <= `MST_MAG4;
      phase_two_level <= `MST_MAG4;
      phase_one_negative <= 1'b0;
      phase_two_negative <= 1'b0;
      decay_mixed <= `MST_DECAY_RST;
   end else begin
      step_prev_ff <= step_lvl;
      if (home_hold) begin
         pos_ff <= `MST_HOME_POS; // [R1] [R8] [R16] [R17]
         phase_one_level <= `MST_MAG4;
         phase_two_level <= `MST_MAG4;
         phase_one_negative <= 1'b0;
         phase_two_negative <= 1'b0;
         decay_mixed <= `MST_DECAY_RST;
      end else if (step_rise) begin
         // dir and resolution only matter here
         pos_ff <= nxt_pos; // [R2] [R4] [R22]
         phase_one_level <= nxt_lvl1; // [R10]
         phase_two_level <= nxt_lvl2; // [R10]
         phase_one_negative <= nxt_cos_idx[4] & (nxt_cos_idx[3:0] != 4'h0);
         phase_two_negative <= nxt_pos[4] & (nxt_pos[3:0] != 4'h0);
         decay_mixed[0] <= nxt_lvl1 < phase_one_level; // [R6] [R7]
         decay_mixed[1] <= nxt_lvl2 < phase_two_level; // [R6] [R7]
      end
   end
end

////////////////////////////////////////////////////////////////////////
// output permission and chopper timing

wire drive_ok;
wire [15:0] off_cyc;
wire [18:0] fast_prod;
wire [15:0] fast_cyc;
wire [15:0] slow_start;
wire [15:0] blank_cyc;
wire [1:0] neg_vec;
wire [1:0] chop_off;
wire [7:0] gate_vec;

// every fault, enable, sleep and reset path removes drive
assign drive_ok = rst_pin_n & ~en_pin_n & sleep_pin_n // [R8] [R14] [R17]
                  & ~reg_fault // [R13]
                  & ~ot_fault & ~cp_low // [R15]
                  & ~lockout; // [R16]

// off-time: fixed default with pin high, else programmed
assign off_cyc = timing_high ? `MST_OFF_DEF_CYC : ({8'h00, off_us_ff} * `MST_CLK_MHZ); // [R11]
// the fast share is cut to whole cycles, never longer than 5/16
assign fast_prod = off_cyc * `MST_FAST_NUM;
assign fast_cyc = {1'b0, fast_prod[18:`MST_FAST_SHIFT]}; // [R19]
assign slow_start = off_cyc - fast_cyc;
assign blank_cyc = `MST_BLANK_CYC;
assign neg_vec = {phase_two_negative, phase_one_negative};

assign phase_one_gates = gate_vec[3:0];
assign phase_two_gates = gate_vec[7:4];

genvar g;
generate
   for (g = 0; g < 2; g = g + 1) begin : chop
      reg [1:0] st_ff;
      reg [15:0] cnt_ff;
      reg [15:0] blank_ff;
      reg mix_ff;
      reg [3:0] gate_ff;
      reg [3:0] nxt_gate;
      wire [3:0] fwd;
      wire [3:0] rev;

      // diagonal pair for the present polarity and its reverse
      assign fwd = neg_vec[g] ? 4'h6 : 4'h9; // [R9]
      assign rev = neg_vec[g] ? 4'h9 : 4'h6;
      assign gate_vec[4*g+3:4*g] = gate_ff;
      assign chop_off[g] = (st_ff == `MST_ST_OFF);

      // on, trip after blanking, one-shot off-time
      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            st_ff <= `MST_ST_DIS;
            cnt_ff <= 16'h0000;
            blank_ff <= 16'h0000;
            mix_ff <= 1'b1;
         end else begin
            case (st_ff)
               `MST_ST_DIS: begin
                  // blanking restarts whenever drive returns
                  if (drive_ok) begin
                     st_ff <= `MST_ST_DRV;
                     blank_ff <= blank_cyc; // [R12]
                  end
               end
               `MST_ST_DRV: begin
                  if (!drive_ok) begin
                     st_ff <= `MST_ST_DIS;
                  end else if (blank_ff != 16'h0000) begin
                     blank_ff <= blank_ff - 16'h0001; // [R12]
                  end else if (trip_lvl[g]) begin
                     // decay mode latched here, a later step acts from the next trip
                     st_ff <= `MST_ST_OFF; // [R9]
                     cnt_ff <= off_cyc; // [R11]
                     mix_ff <= decay_mixed[g];
                  end
               end
               `MST_ST_OFF: begin
                  if (!drive_ok) begin
                     st_ff <= `MST_ST_DIS;
                  end else if (cnt_ff <= 16'h0001) begin
                     st_ff <= `MST_ST_DRV;
                     blank_ff <= blank_cyc; // [R12]
                  end else begin
                     cnt_ff <= cnt_ff - 16'h0001; // [R11]
                  end
               end
               default: st_ff <= `MST_ST_DIS;
            endcase
         end
      end

      // gate pattern: drive, fast reverse, slow sinks, or all off
      always @* begin
         case (st_ff)
            `MST_ST_DRV: nxt_gate = fwd; // [R9]
            `MST_ST_OFF: begin
               if (zero_lvl[g]) begin
                  nxt_gate = 4'h0; // [R20]
               end else if (mix_ff && cnt_ff > slow_start) begin
                  nxt_gate = rev; // [R19] [R20]
               end else begin
                  nxt_gate = 4'h5; // [R9] [R20]
               end
            end
            default: nxt_gate = 4'h0;
         endcase
      end

      // registered gates, cut at once when drive is withdrawn
      // one cycle of gate lag keeps every pattern change glitch free
      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gate_ff <= 4'h0;
         end else begin
            gate_ff <= drive_ok ? nxt_gate : 4'h0; // [R8] [R13] [R14] [R15]
         end
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// readback words

// status: [14:10] supervisor pins, [9:8] off-time per phase,
// [7] drive allowed, [6:5] decay, [4:0] position
assign status_word = {17'h00000, timing_high, lockout, cp_low, ot_fault, reg_fault,
                      chop_off, drive_ok, decay_mixed, pos_ff};
assign levels_word = {1'b0, phase_two_negative, phase_two_level,
                      1'b0, phase_one_negative, phase_one_level};

endmodule

// [verification/mst_props.sv]
// assertions on the translator ports: output gating, homing, decay select
// assumes it is bound onto mst_translator, one pclk domain
module mst_props (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // control and supervisor pins
   input wire reset_n,
   input wire enable_n,
   input wire sleep_n,
   input wire internal_gate_regulator_fault,
   input wire overtemp_fault,
   input wire charge_pump_supply_low,
   input wire supply_lockout,
   // levels, decay and gates
   input wire [13:0] phase_one_level,
   input wire [13:0] phase_two_level,
   input wire [1:0] decay_mixed,
   input wire [3:0] phase_one_gates,
   input wire [3:0] phase_two_gates
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] quiet_ff;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   // cycles since a homing pin was last active, so homing is not taken for a step
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_ff <= 4'h0;
      end else if (!reset_n || !sleep_n || supply_lockout) begin
         quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hf) begin
         quiet_ff <= quiet_ff + 4'h1;
      end
   end
   // a cause held long enough to pass the pin synchronisers leaves every gate off
   property p_off(c);
      c [*8] |-> phase_one_gates == 4'h0 && phase_two_gates == 4'h0;
   endproperty
   ////////////////////////////////////////////////////////////////
   a_reset_home: assert property ($rose(presetn) |-> phase_one_level == 14'h1b9f && decay_mixed == 2'h3)
      else $error("levels or decay not home after reset");
   a_pin_reset_home: assert property (!reset_n [*8] |-> phase_two_level == 14'h1b9f && decay_mixed == 2'h3)
      else $error("translator not home under reset pin");
   a_pin_reset_off: assert property (p_off(!reset_n))
      else $error("gates on under reset pin");
   a_enable_off: assert property (p_off(enable_n))
      else $error("gates on while disabled");
   a_sleep_off: assert property (p_off(!sleep_n))
      else $error("gates on in sleep");
   a_regulator_off: assert property (p_off(internal_gate_regulator_fault))
      else $error("gates on with regulator fault");
   a_shutdown_off: assert property (p_off(overtemp_fault || charge_pump_supply_low))
      else $error("gates on with shutdown fault");
   a_lockout_off: assert property (p_off(supply_lockout))
      else $error("gates on in lockout");
   a_decay_one: assert property (quiet_ff == 4'hf && $changed(phase_one_level) |->
      decay_mixed[0] == (phase_one_level < $past(phase_one_level))) else $error("phase one decay wrong");
   a_decay_two: assert property (quiet_ff == 4'hf && $changed(phase_two_level) |->
      decay_mixed[1] == (phase_two_level < $past(phase_two_level))) else $error("phase two decay wrong");
   // main scenarios
   c_step: cover property (quiet_ff == 4'hf && $changed(phase_one_level));
   c_fast: cover property (phase_one_gates == 4'h6);
   c_slow: cover property (phase_two_gates == 4'h5);
endmodule
bind mst_translator mst_props mst_props_inst (.*);

// [verification/mst_step_ctrl.sv]
// controller model: step, direction, resolution and control pins
// assumes the bench calls its tasks from one process clocked by pclk
module mst_step_ctrl #(
   parameter int wake_cyc = 125000 // 1 ms at 125 MHz
) (
   // clock
   input wire logic pclk,
   // controller pins
   output logic step,
   output logic dir,
   output logic resolution_select_low,
   output logic resolution_select_high,
   output logic reset_n,
   output logic enable_n,
   output logic sleep_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int since_wake = 0;
   ////////////////////////////////////////////////////////////////
   // idle levels at time zero
   initial begin
      {step, dir, resolution_select_high, resolution_select_low} = 4'h0;
      {reset_n, enable_n, sleep_n} = 3'b101;
   end
   // cycles since sleep was released
   always @(posedge pclk) begin
      since_wake <= sleep_n ? since_wake + 1 : 0;
   end
   ////////////////////////////////////////////////////////////////
   task automatic pins(input logic r, input logic e, input logic s);
      @(posedge pclk);
      {reset_n, enable_n, sleep_n} <= {r, e, s};
   endtask
   // direction and resolution set up well before the step edge
   task automatic setup(input logic d, input logic [1:0] res);
      @(posedge pclk);
      dir <= d;
      {resolution_select_high, resolution_select_low} <= res;
   endtask
   // one step, high and low long enough to pass the synchronisers
   task automatic step_once();
      while (since_wake < wake_cyc) @(posedge pclk);
      @(posedge pclk);
      step <= 1'b1;
      repeat (4) @(posedge pclk);
      step <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
endmodule

// [verification/test_mst_translator.sv]
// self-checking bench for the translator and chopper control
// assumes mst_step_ctrl drives the controller pins and mst_props is bound
`include "mst_defines.vh"
module test_mst_translator;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic internal_gate_regulator_fault = 0, overtemp_fault = 0, charge_pump_supply_low = 0, supply_lockout = 0;
   logic offtime_timing_pin = 1, phase_one_zero_current = 0, phase_two_zero_current = 0;
   logic phase_one_sense_trip = 0, phase_two_sense_trip = 0;
   wire [31:0] prdata;
   wire pready, pslverr, step, dir, resolution_select_low, resolution_select_high, reset_n, enable_n, sleep_n;
   wire [13:0] phase_one_level, phase_two_level;
   wire phase_one_negative, phase_two_negative;
   wire [1:0] decay_mixed;
   wire [3:0] phase_one_gates, phase_two_gates;
   logic [13:0] mag [0:8] = '{`MST_MAG0, `MST_MAG1, `MST_MAG2, `MST_MAG3, `MST_MAG4, `MST_MAG5, `MST_MAG6,
      `MST_MAG7, `MST_MAG8};
   int fail_count = 0, checks = 0, cyc = 0, idx = 4, k, n;
   mst_translator mst_translator_inst (.*);
   mst_step_ctrl #(.wake_cyc(200)) mst_step_ctrl_inst (.*);
   ////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (fail_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   ////////////////////////////////////////////////////////////////
   // {negative, level} of sin at index a eighth steps
   function automatic logic [14:0] wave(input int a);
      int q;
      logic [13:0] m;
      q = (a / 8) % 4;
      m = (q % 2) ? mag[8 - a % 8] : mag[a % 8];
      return {q >= 2 && m != 0, m};
   endfunction
   task automatic home_chk();
      idx = 4;
      chk(32'({phase_one_negative, phase_one_level}), 32'(wave(12)));
      chk(32'({phase_two_negative, phase_two_level}), 32'(wave(4)));
      chk(32'(decay_mixed), 32'h3);
   endtask
   task automatic gates_off();
      chk(32'({phase_one_gates, phase_two_gates}), 32'h0);
   endtask
   // one step, resolution change alone must not move the translator
   task automatic step_chk(input logic d, input logic [1:0] res);
      logic [14:0] o1, o2, n1, n2;
      o1 = {phase_one_negative, phase_one_level};
      o2 = {phase_two_negative, phase_two_level};
      mst_step_ctrl_inst.setup(d, res);
      repeat (8) @(posedge pclk);
      chk(32'({phase_one_negative, phase_one_level}), 32'(o1));
      mst_step_ctrl_inst.step_once();
      idx = (idx + (d ? (8 >> res) : 32 - (8 >> res))) % 32;
      n1 = wave(idx + 8);
      n2 = wave(idx);
      chk(32'({phase_one_negative, phase_one_level}), 32'(n1));
      chk(32'({phase_two_negative, phase_two_level}), 32'(n2));
      chk(32'(decay_mixed), 32'({n2[13:0] < o2[13:0], n1[13:0] < o1[13:0]}));
   endtask
   // reset pin: steps ignored, gates off, home after release
   task automatic t_home();
      mst_step_ctrl_inst.pins(0, 0, 1);
      mst_step_ctrl_inst.setup(1, 2'b00);
      mst_step_ctrl_inst.step_once();
      gates_off();
      mst_step_ctrl_inst.pins(1, 0, 1);
      repeat (8) @(posedge pclk);
      home_chk();
   endtask
   // sleep, lockout, disable and faults all force the gates off
   task automatic t_gate_off();
      step_chk(1, 2'b00);
      mst_step_ctrl_inst.pins(1, 0, 0);
      repeat (10) @(posedge pclk);
      gates_off();
      mst_step_ctrl_inst.pins(1, 0, 1);
      repeat (8) @(posedge pclk);
      home_chk();
      step_chk(1, 2'b00);
      supply_lockout <= 1'b1;
      repeat (10) @(posedge pclk);
      gates_off();
      home_chk();
      supply_lockout <= 1'b0;
      mst_step_ctrl_inst.pins(1, 1, 1);
      step_chk(0, 2'b01);
      gates_off();
      mst_step_ctrl_inst.pins(1, 0, 1);
      for (int f = 0; f < 3; f++) begin
         repeat (10) @(posedge pclk);
         {internal_gate_regulator_fault, overtemp_fault, charge_pump_supply_low} <= 3'b100 >> f;
         repeat (10) @(posedge pclk);
         gates_off();
         {internal_gate_regulator_fault, overtemp_fault, charge_pump_supply_low} <= 3'b000;
      end
   endtask
   // off-time from the control register, blanking, mixed then slow decay
   task automatic t_chop();
      apb(1, `MST_ADDR_CTRL, 32'h10);
      apb(0, `MST_ADDR_CTRL, 32'h0);
      chk(rd, 32'h10);
      apb(1, 12'h0fc, 32'h1);
      chk(32'(err), 32'h1);
      offtime_timing_pin <= 1'b0;
      t_home();
      for (k = 0; k < 40 && phase_one_gates !== 4'h9; k++) @(posedge pclk);
      phase_one_sense_trip <= 1'b1;
      repeat (100) @(posedge pclk);
      chk(32'(phase_one_gates), 32'h9);
      for (k = 0; k < 60 && phase_one_gates === 4'h9; k++) @(posedge pclk);
      phase_one_sense_trip <= 1'b0;
      chk(32'(phase_one_gates), 32'h6);
      for (n = 0; n < 700 && phase_one_gates === 4'h6; n++) @(posedge pclk);
      chk(32'(n >= 624 && n <= 626), 32'h1);
      for (k = 0; k < 1600 && phase_one_gates !== 4'h9; k++) begin
         phase_one_zero_current <= (k >= 100 && k < 110);
         if (k == 108) chk(32'(phase_one_gates), 32'h0);
         @(posedge pclk);
      end
      chk(32'(n + k >= 1998 && n + k <= 2002), 32'h1);
      step_chk(1, 2'b11);
      for (k = 0; k < 200 && phase_two_gates !== 4'h9; k++) @(posedge pclk);
      repeat (130) @(posedge pclk);
      phase_two_sense_trip <= 1'b1;
      for (k = 0; k < 20 && phase_two_gates === 4'h9; k++) @(posedge pclk);
      phase_two_sense_trip <= 1'b0;
      chk(32'(phase_two_gates), 32'h5);
      apb(0, `MST_ADDR_LEVELS, 32'h0);
      chk(rd, 32'({1'b0, wave(idx), 1'b0, wave(idx + 8)}));
      apb(0, `MST_ADDR_STATUS, 32'h0);
      chk(rd & 32'h1f, 32'(idx));
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      home_chk();
      step_chk(1, 2'b11);
      step_chk(1, 2'b10);
      step_chk(1, 2'b01);
      step_chk(1, 2'b00);
      step_chk(0, 2'b00);
      step_chk(0, 2'b11);
      step_chk(0, 2'b00);
      step_chk(0, 2'b00);
      t_home();
      t_gate_off();
      t_chop();
      print_verdict();
   end
endmodule
